// [verif/mcu_irq_model.sv]
// partner: microcontroller side that services the interrupt flags
`default_nettype none
module mcu_irq_model (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic wd_event_irq,
    input  wire logic irq_n,
    input  wire logic stall,
    output logic      irq_flags_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    // flags set by events; unless stall is high, a fast host clears them at once, so the
    // minimum low time is what keeps the line down
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq_flags_pending <= 1'b0;
        else if (wd_event_irq)
            irq_flags_pending <= 1'b1;
        else if (!irq_n && !stall)
            irq_flags_pending <= 1'b0;
    end
endmodule : mcu_irq_model
`default_nettype wire

// [verif/test_window_supervisor.sv]
// testbench: windows, triggers, error counter and interrupt timing
`default_nettype none
module test_window_supervisor;
    import window_supervisor_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst_n, trigger_pin, spi_chip_select_n, spi_service_write;
    logic spi_config_write, active_state, mcu_reset_released, stall;
    logic programming_support_pin, other_reset_request, voltage_fault_in;
    logic irq_flags_pending, init_timer_expired, missed_irq_clear, irq_n;
    logic mcu_reset_request, init_timer_enable, voltage_fault_out;
    logic wd_error_event, missed_irq_flag, wd_event_irq;
    logic [ERR_W-1:0] error_count;
    wd_config_type    spi_config;
    int               n_mismatch = 0;
    int               total_checks = 0;
    int               row_wait [5] = '{100, 100, 100, 2200, 4200};
    logic [ERR_W-1:0] row_err [5] = '{8'h00, 8'h02, 8'h01, 8'h00, 8'h01};
    logic             row_evt [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    window_supervisor #(.LONG_OPEN_CYCLES(200), .FILTER_CYCLES(4)) DUT (.*);
    mcu_irq_model partner (.*);
    always #2.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [ERR_W-1:0] seen, exp, input string m);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk
    // inputs always move one ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic svc_trig();
        spi_chip_select_n = 1'b0;
        spi_service_write = 1'b1;
        tick(1);
        spi_service_write = 1'b0;
        spi_chip_select_n = 1'b1;
    endtask : svc_trig
    // one-cycle windows of 10 us, threshold one
    task automatic cfg_load(input logic src);
        spi_config = '{src, 1'b0, 8'h01, 8'h01, 8'h01};
        spi_config_write = 1'b1;
        tick(1);
        spi_config_write = 1'b0;
    endtask : cfg_load
    task automatic do_reset();
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(1);
    endtask : do_reset
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////
    // watchdog: the whole run needs about 82k cycles
    initial
    begin
        #500000;
        n_mismatch++;
        wrap_up();
    end
    initial
    begin
        {clk_sys, trigger_pin, spi_service_write, spi_config_write} = '0;
        {programming_support_pin, other_reset_request, stall} = '0;
        {voltage_fault_in, init_timer_expired, missed_irq_clear} = '0;
        {spi_chip_select_n, active_state, mcu_reset_released} = '1;
        spi_config = '0;
        do_reset();
        chk(ERR_W'(irq_n), 8'h01, "irq idle");
        cfg_load(SRC_SPI);
        for (int i = 0; i < 5; i++)
        begin
            tick(row_wait[i]);
            svc_trig();
            tick(10);
            chk(error_count, row_err[i], "count");
            chk(ERR_W'(wd_error_event), ERR_W'(row_evt[i]), "evt");
        end
        chk(ERR_W'(irq_n), 8'h00, "irq held low");
        tick(14000);
        chk(ERR_W'(irq_n), 8'h01, "irq back high");
        $display("test spi rows done");
        // pin source: rising edge and spi frame must be ignored
        stall = 1'b1;
        do_reset();
        cfg_load(SRC_PIN);
        tick(50);
        trigger_pin = 1'b1;
        tick(50);
        svc_trig();
        tick(50);
        trigger_pin = 1'b0;
        tick(50);
        trigger_pin = 1'b1;
        tick(50);
        trigger_pin = 1'b0;
        tick(50);
        chk(error_count, 8'h02, "pin edges");
        chk(ERR_W'(irq_n), 8'h00, "irq low");
        tick(61000);
        chk(ERR_W'(irq_n), 8'h01, "time-out");
        chk(ERR_W'(missed_irq_flag), 8'h01, "missed set");
        missed_irq_clear = 1'b1;
        tick(1);
        missed_irq_clear = 1'b0;
        tick(1);
        chk(ERR_W'(missed_irq_flag), 8'h00, "missed clr");
        $display("test pin and irq done");
        // programming mode with the watchdog fault standing
        voltage_fault_in = 1'b1;
        tick(1);
        chk(ERR_W'(voltage_fault_out), 8'h01, "vfault");
        voltage_fault_in = 1'b0;
        programming_support_pin = 1'b1;
        tick(2);
        chk(ERR_W'(mcu_reset_request), 8'h00, "mps block");
        chk(ERR_W'(init_timer_enable), 8'h00, "init off");
        other_reset_request = 1'b1;
        tick(1);
        chk(ERR_W'(mcu_reset_request), 8'h01, "other rst");
        $display("test programming mode done");
        wrap_up();
    end
endmodule : test_window_supervisor
`default_nettype wire

// [verif/window_supervisor_monitor.sv]
// checker: port-level timing checks of the window supervisor
`default_nettype none
module window_supervisor_monitor
    import window_supervisor_pkg::*;
#(
    parameter int unsigned LONG_OPEN_CYCLES = 200,
    parameter int unsigned FILTER_CYCLES    = 4
)(
    input wire logic             clk_sys,
    input wire logic             rst_n,
    input wire logic             irq_n,
    input wire logic             mcu_reset_released,
    input wire logic             programming_support_pin,
    input wire logic             other_reset_request,
    input wire logic             voltage_fault_in,
    input wire logic             voltage_fault_out,
    input wire logic             init_timer_enable,
    input wire logic             mcu_reset_request,
    input wire logic             wd_event_irq,
    input wire logic [ERR_W-1:0] error_count
);
    localparam int LOW_MIN  = IRQ_LOW_CYC - 2;
    localparam int TO_MAX   = IRQ_TO_CYC + 2;
    localparam int HIGH_MIN = IRQ_HIGH_CYC - 2;
    logic [16:0] lc_q;
    logic [16:0] hc_q;
    logic        seen_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // low and high run lengths of the line; high count saturates
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lc_q   <= '0;
            hc_q   <= '0;
            seen_q <= 1'b0;
        end
        else
        begin
            lc_q   <= irq_n ? '0 : lc_q + 17'h0_0001;
            hc_q   <= !irq_n ? '0 : (&hc_q ? hc_q : hc_q + 17'h0_0001);
            seen_q <= seen_q | !irq_n;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // counter moves only by +2, -1 or saturates at the top
    AST_ERR_STEP: assert property (error_count != $past(error_count) |->
        error_count == $past(error_count) + ERR_INC ||
        error_count == $past(error_count) - ERR_DEC ||
        error_count == 8'hff) else $error("bad error count step");
    AST_DEC_NO_IRQ: assert property ($past(error_count) > error_count |->
        !wd_event_irq) else $error("irq on valid trigger");
    AST_INIT_TIMER: assert property (init_timer_enable ==
        !programming_support_pin) else $error("init timer gate");
    AST_FAULT_PASS: assert property (voltage_fault_out == voltage_fault_in)
        else $error("voltage fault lost");
    AST_MPS_BLOCK: assert property (programming_support_pin &&
        !other_reset_request && !voltage_fault_in |-> !mcu_reset_request)
        else $error("reset in programming mode");
    AST_OTHER_RESET: assert property (other_reset_request |->
        mcu_reset_request) else $error("other reset blocked");
    AST_IRQ_LOW_MIN: assert property ($rose(irq_n) |-> lc_q >= LOW_MIN)
        else $error("irq low too short");
    AST_IRQ_TIMEOUT: assert property (!irq_n && mcu_reset_released |->
        lc_q <= TO_MAX) else $error("irq low past time-out");
    AST_IRQ_HIGH_MIN: assert property ($fell(irq_n) && seen_q |->
        hc_q >= HIGH_MIN) else $error("irq high too short");
endmodule : window_supervisor_monitor
bind window_supervisor window_supervisor_monitor #(
    .LONG_OPEN_CYCLES(LONG_OPEN_CYCLES),
    .FILTER_CYCLES   (FILTER_CYCLES)
) u_monitor (.*);
`default_nettype wire

// [verilog/window_supervisor.sv]
// window watchdog supervisor with pin/spi triggers and interrupt timing
`default_nettype none
// How it works
// - trigger from pin or spi write, one selected, spi after reset.
// - trigger in open window starts closed window, then new open window.
// - valid trigger decrements error counter if above zero, no interrupt.
// - trigger in closed window: new open window, add two, interrupt.
// - open window elapsing without trigger: add two, interrupt, reopen.
// - window length is base cycle 10 or 100 us times count.
// - configuration accepted only in active state.
// - reset release in active state starts a 600 ms long window.
// - config change in long window restarts with a regular open window.
// - only falling edges of the trigger pin count.
// - trigger pin passes a 400 us sampling filter.
// - spi trigger instant is the chip select rising edge.
// - error event while counter exceeds threshold.
// - programming mode blocks watchdog reset, other resets still pass.
// - programming mode keeps interrupts, disables init timer.
// - programming mode independent of state; keep device active.
// - voltage faults still act during programming mode.
// - interrupt line low for at least 100 us.
// - line released after 300 us time-out while reset is released.
// - line stays high at least 300 us before next assertion.
// - interrupt requested in high interval is held until it ends.
// - time-out release sets missed flag without new interrupt.
module window_supervisor
    import window_supervisor_pkg::*;
#(
    parameter int unsigned LONG_OPEN_CYCLES = LONG_OPEN_CYC,
    parameter int unsigned FILTER_CYCLES    = FILTER_CYC
)(
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    input  wire logic          trigger_pin,
    input  wire logic          spi_chip_select_n,
    input  wire logic          spi_service_write,
    input  wire logic          spi_config_write,
    input  wire wd_config_type spi_config,
    input  wire logic          active_state,
    input  wire logic          mcu_reset_released,
    input  wire logic          programming_support_pin,
    input  wire logic          other_reset_request,
    input  wire logic          voltage_fault_in,
    input  wire logic          irq_flags_pending,
    input  wire logic          init_timer_expired,
    input  wire logic          missed_irq_clear,
    output logic               irq_n,
    output logic               mcu_reset_request,
    output logic               init_timer_enable,
    output logic               voltage_fault_out,
    output logic               wd_error_event,
    output logic               missed_irq_flag,
    output logic [ERR_W-1:0]   error_count,
    output logic               wd_event_irq
);
    initial
    begin
        if (LONG_OPEN_CYCLES < 1 || FILTER_CYCLES < 1)
            $error("window_supervisor: cycle counts must be at least one");
    end

    typedef struct packed {
        logic [1:0]         pin_sync;
        logic [1:0]         scs_sync;
        logic               scs_prev;
        logic               pin_filt;
        logic [TIMER_W-1:0] filt_cnt;
        logic               spi_armed;
        wd_config_type      cfg;
        wd_state_type       wd_state;
        logic [TIMER_W-1:0] win_cnt;
        logic [ERR_W-1:0]   err;
        irq_state_type      irq_state;
        logic [TIMER_W-1:0] irq_cnt;
        logic               irq_held;
        logic               missed;
        logic               wd_irq;
        logic               flags_prev;
    } state_type;

    state_type s_q, s_d;

    // window length in clock cycles from base option and count
    function automatic logic [TIMER_W-1:0] win_len(input logic base,
                                                   input logic [CNT_W-1:0] n);
        logic [TIMER_W-1:0] unit;
        unit = base ? TIMER_W'(BASE1_CYC) : TIMER_W'(BASE0_CYC);
        return TIMER_W'(unit * TIMER_W'(n));
    endfunction : win_len

    // saturating add of two
    function automatic logic [ERR_W-1:0] err_up(input logic [ERR_W-1:0] e);
        return (e > {ERR_W{1'b1}} - ERR_INC) ? {ERR_W{1'b1}} : e + ERR_INC;
    endfunction : err_up

    // combinational helpers, each given a value early in the comb process
    // pin_fall: filtered falling edge of the trigger pin
    // spi_trig: chip select rising edge that closes an armed service frame
    // trig:     the edge of whichever source the configuration selects
    // new_flag: a flag that was not pending in the cycle before
    logic pin_fall;
    logic spi_trig;
    logic trig;
    logic new_flag;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_d = s_q;
        s_d.wd_irq = 1'b0;
        // synchronisers: first stage only feeds the second
        s_d.pin_sync = {s_q.pin_sync[0], trigger_pin};
        s_d.scs_sync = {s_q.scs_sync[0], spi_chip_select_n};
        // edge detection keeps its own copy of the synchronised level, so
        // the metastable first stage is never read by any other logic
        s_d.scs_prev = s_q.scs_sync[1];
        // pending flags are remembered so that only new ones drive the line;
        // flags left standing after a time-out must not pull it low again
        s_d.flags_prev = irq_flags_pending;
        new_flag = irq_flags_pending & ~s_q.flags_prev;
        pin_fall = 1'b0;
        // sampling filter: new level accepted after stable for filter time
        if (s_q.pin_sync[1] == s_q.pin_filt)
            s_d.filt_cnt = '0;
        else if (s_q.filt_cnt >= TIMER_W'(FILTER_CYCLES - 1))
        begin
            s_d.filt_cnt = '0;
            s_d.pin_filt = s_q.pin_sync[1];
            pin_fall     = s_q.pin_filt & ~s_q.pin_sync[1];
        end
        else
            s_d.filt_cnt = s_q.filt_cnt + 1'b1;

        // spi trigger fires on chip select rising edge after a service write
        if (spi_service_write)
            s_d.spi_armed = 1'b1;
        // a frame without a service write leaves the trigger unarmed, so
        // configuration or status frames never count as a trigger
        spi_trig = s_q.spi_armed & s_q.scs_sync[1] & ~s_q.scs_prev;
        if (spi_trig)
            s_d.spi_armed = 1'b0;

        trig = (s_q.cfg.trigger_source == SRC_PIN) ? pin_fall : spi_trig;

        // window state machine
        // the long window accepts a trigger like an open one; a trigger in
        // the closed window aborts it and charges the error counter
        // limitation: window counts of zero expire at once
        if (s_q.win_cnt != '0)
            s_d.win_cnt = s_q.win_cnt - 1'b1;
        case (s_q.wd_state)
            ST_OFF:
            begin
                if (active_state && mcu_reset_released)
                begin
                    s_d.wd_state = ST_LONG;
                    s_d.win_cnt  = TIMER_W'(LONG_OPEN_CYCLES - 1);
                end
            end
            ST_LONG, ST_OPEN:
            begin
                if (trig)
                begin
                    s_d.wd_state = ST_CLOSED;
                    s_d.win_cnt  = win_len(s_q.cfg.window_base_cycle,
                                           s_q.cfg.closed_window_count);
                    if (s_q.err != '0)
                        s_d.err = s_q.err - ERR_DEC;
                end
                else if (s_q.win_cnt == '0)
                begin
                    s_d.wd_state = ST_OPEN;
                    s_d.win_cnt  = win_len(s_q.cfg.window_base_cycle,
                                           s_q.cfg.open_window_count);
                    s_d.err      = err_up(s_q.err);
                    s_d.wd_irq   = 1'b1;
                end
            end
            ST_CLOSED:
            begin
                if (trig || s_q.win_cnt == '0)
                begin
                    s_d.wd_state = ST_OPEN;
                    s_d.win_cnt  = win_len(s_q.cfg.window_base_cycle,
                                           s_q.cfg.open_window_count);
                end
                if (trig)
                begin
                    s_d.err    = err_up(s_q.err);
                    s_d.wd_irq = 1'b1;
                end
            end
            default: s_d.wd_state = ST_OFF;
        endcase

        // configuration only in active state
        if (spi_config_write && active_state)
        begin
            s_d.cfg = spi_config;
            if (s_q.wd_state == ST_LONG)
            begin
                s_d.wd_state = ST_OPEN;
                s_d.win_cnt  = win_len(spi_config.window_base_cycle,
                                       spi_config.open_window_count);
            end
        end
        // leaving active or reasserting reset stops the watchdog
        if (!active_state || !mcu_reset_released)
            s_d.wd_state = ST_OFF;

        // interrupt line timing
        // one counter serves all three intervals: it is reloaded on every
        // change of line state and counts down to zero
        // low: released after the minimum low time once the flags are
        //      cleared, or at the time-out while the reset is released
        // high: kept for the minimum high time before the next assertion
        if (s_q.irq_cnt != '0)
            s_d.irq_cnt = s_q.irq_cnt - 1'b1;
        // missed flag: clear first so that a time-out in the same cycle wins
        if (missed_irq_clear)
            s_d.missed = 1'b0;
        if (new_flag && s_q.irq_state == IRQ_HIGH)
            s_d.irq_held = 1'b1;
        case (s_q.irq_state)
            IRQ_IDLE:
            begin
                if (new_flag || s_q.irq_held)
                begin
                    s_d.irq_state = IRQ_LOW;
                    s_d.irq_cnt   = TIMER_W'(IRQ_TO_CYC - 1);
                    s_d.irq_held  = 1'b0;
                end
            end
            IRQ_LOW:
            begin
                // min low elapsed once count <= timeout - min low
                if (s_q.irq_cnt == '0 && mcu_reset_released)
                begin
                    s_d.irq_state = IRQ_HIGH;
                    s_d.irq_cnt   = TIMER_W'(IRQ_HIGH_CYC - 1);
                    s_d.missed    = 1'b1;
                end
                else if (!irq_flags_pending &&
                         s_q.irq_cnt <= TIMER_W'(IRQ_TO_CYC - IRQ_LOW_CYC))
                begin
                    s_d.irq_state = IRQ_HIGH;
                    s_d.irq_cnt   = TIMER_W'(IRQ_HIGH_CYC - 1);
                end
            end
            IRQ_HIGH:
            begin
                if (s_q.irq_cnt == '0)
                    s_d.irq_state = IRQ_IDLE;
            end
            default: s_d.irq_state = IRQ_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    // the trigger pin idles low through its pull-down, so its synchroniser
    // and filter start low: a high start would fake a falling edge after
    // every reset; chip select idles high for the same reason
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q           <= '0;
            s_q.pin_sync  <= 2'b00;
            s_q.scs_sync  <= 2'b11;
            s_q.scs_prev  <= 1'b1;
            s_q.pin_filt  <= 1'b0;
            s_q.cfg.trigger_source <= SRC_SPI;
            s_q.wd_state  <= ST_OFF;
            s_q.irq_state <= IRQ_IDLE;
        end
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; watchdog errors do not reach reset in programming mode
    // the error event is a level, compared every cycle against the current
    // threshold, so lowering the threshold raises the event at once
    assign wd_error_event    = (s_q.err > s_q.cfg.threshold);
    assign mcu_reset_request = other_reset_request |
                               (wd_error_event & ~programming_support_pin);
    assign init_timer_enable = ~programming_support_pin;
    assign voltage_fault_out = voltage_fault_in;
    assign irq_n             = (s_q.irq_state != IRQ_LOW);
    assign missed_irq_flag   = s_q.missed;
    assign error_count       = s_q.err;
    assign wd_event_irq      = s_q.wd_irq;

    // the initialization timer lives outside this block; only its enable
    // is produced here, its expiry is not acted on
    logic unused_ok;
    assign unused_ok = init_timer_expired;
endmodule : window_supervisor
`default_nettype wire

// [verilog/window_supervisor_pkg.sv]
// package: constants and types for the window watchdog supervisor
`default_nettype none
package window_supervisor_pkg;
    localparam int unsigned CLK_MHZ       = 200;
    // times in their own units
    localparam int unsigned BASE0_US      = 10;
    localparam int unsigned BASE1_US      = 100;
    localparam int unsigned LONG_OPEN_MS  = 600;
    localparam int unsigned FILTER_US     = 400;
    localparam int unsigned IRQ_LOW_US    = 100;
    localparam int unsigned IRQ_TO_US     = 300;
    localparam int unsigned IRQ_HIGH_US   = 300;
    // derived cycle counts
    localparam int unsigned BASE0_CYC     = BASE0_US * CLK_MHZ;
    localparam int unsigned BASE1_CYC     = BASE1_US * CLK_MHZ;
    localparam int unsigned LONG_OPEN_CYC = LONG_OPEN_MS * 1000 * CLK_MHZ;
    localparam int unsigned FILTER_CYC    = FILTER_US * CLK_MHZ;
    localparam int unsigned IRQ_LOW_CYC   = IRQ_LOW_US * CLK_MHZ;
    localparam int unsigned IRQ_TO_CYC    = IRQ_TO_US * CLK_MHZ;
    localparam int unsigned IRQ_HIGH_CYC  = IRQ_HIGH_US * CLK_MHZ;
    localparam int unsigned TIMER_W       = 32;
    localparam int unsigned CNT_W         = 8;
    localparam int unsigned ERR_W         = 8;
    localparam logic [ERR_W-1:0] ERR_INC  = 8'h02;
    localparam logic [ERR_W-1:0] ERR_DEC  = 8'h01;
    localparam logic         SRC_SPI      = 1'b0;
    localparam logic         SRC_PIN      = 1'b1;

    typedef enum {ST_OFF, ST_LONG, ST_OPEN, ST_CLOSED} wd_state_type;
    typedef enum {IRQ_IDLE, IRQ_LOW, IRQ_HIGH} irq_state_type;

    typedef struct packed {
        logic             trigger_source;
        logic             window_base_cycle;
        logic [CNT_W-1:0] open_window_count;
        logic [CNT_W-1:0] closed_window_count;
        logic [ERR_W-1:0] threshold;
    } wd_config_type;
endpackage : window_supervisor_pkg
`default_nettype wire
